// ==== tdm_link_params.svh ====
// Register offsets, field positions and framing constants of the serial link port
`ifndef TDM_LINK_PARAMS_SVH
`define TDM_LINK_PARAMS_SVH
`define ADDR_RECOMB_STAT 16'h02ad
`define ADDR_TX_CTRL     16'h0600
`define ADDR_TX_MASK_LO  16'h0610
`define ADDR_TX_MASK_HI  16'h0611
`define ADDR_RX_CTRL     16'h0700
`define ADDR_RX_MASK_LO  16'h0710
`define ADDR_RX_MASK_HI  16'h0711
`define ADDR_RX_STAT     16'h0720
`define FLD_FP_POL       0
`define FLD_EDGE         1
`define FLD_BUS          2
`define FLD_MUX_LO       3
`define FLD_MUX_HI       4
`define FLD_RATE_LO      5
`define FLD_RATE_HI      6
`define FLD_EN           7
`define FLD_PORT_EN      8
`define FLD_DELIN        10
`define STAT_OVF         0
`define STAT_EMPTY       1
`define STAT_CNT_LO      8
`define STAT_CNT_HI      15
`define RATE_T1          2'h0
`define RATE_E1          2'h1
`define T1_PAYLOAD_BITS  9'h0c0
`define E1_FRAME_BITS    9'h100
`define CNT_MAX          9'h1ff
`define CELL_BYTES       53
`define FIFO_CELLS       4
`define CELL_LAST        6'h34
`define HDR_LAST         6'h03
`define HDR_BYTES        3'h4
`define IDLE_HDR         32'h00000001
`endif

// ==== tdm_link_pkg.sv ====
// Types shared by the serial link port
package tdm_link_pkg;
  // Link grouping encodings
  typedef enum logic [1:0] {MUX_SINGLE, MUX_PAIR, MUX_QUAD, MUX_RSVD} mux_e;
  // Raw link pins, sampled as one group
  typedef struct packed {
    logic tx_clk;
    logic tx_fp;
    logic ltx_clk;
    logic ltx_fp;
    logic rx_clk;
    logic rx_fp;
    logic rx_d;
    logic lrx_clk;
    logic lrx_fp;
    logic lrx_d;
  } pins_s;
  // Result of one timing step
  typedef struct packed {
    logic       ev;
    logic       ph;
    logic [8:0] cnt;
  } step_s;
  // Position of a bit within the frame
  typedef struct packed {
    logic       valid;
    logic [4:0] slot;
    logic [2:0] bit_i;
  } pos_s;
endpackage

// ==== tdm_link_timeslot_port.sv ====
// Serial time-slot link port with receive cell FIFO and register port
//
// The plain strobed port is this design's own decision.
`include "tdm_link_params.svh"
//
// Behaviour
// - Transmit and receive halves run independently
// - Two 16-bit slot masks per direction
// - Mask one carries data, zero floats output
// - T1 frame: 193 bits, first bit unused
// - T1 payload uses lowest 24 mask bits
// - Control fields select rate, grouping, clocking
// - 2.048 MHz generic: 32 slots, pulse marks slot zero
// - 4.096 MHz bus: two clocks per bit
// - Frame pulse polarity and clock edge selectable
// - Pair mode: odd link follows even link
// - Quad mode: three links follow first link
// - Idle cells dropped; FIFO holds four cells
// - Enabling cell port flushes its FIFO

// Byte FIFO with flop storage and flush
module cell_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = `CELL_BYTES * `FIFO_CELLS
) (
  input  wire logic                         clk,
  input  wire logic                         rst,
  input  wire logic                         flush,
  input  wire logic [WIDTH-1:0]             in_data,
  input  wire logic                         in_valid,
  output logic                              in_ready,
  output logic [WIDTH-1:0]                  out_data,
  output logic                              out_valid,
  input  wire logic                         out_ready,
  output logic [$clog2(DEPTH+1)-1:0]        count
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);
  localparam logic [CW-1:0] FULL = CW'(DEPTH);

  // Whole FIFO state
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;  // Storage words
    logic [AW-1:0]               rd;   // Read index
    logic [AW-1:0]               wr;   // Write index
    logic [CW-1:0]               cnt;  // Words held
  } fifo_s;

  fifo_s s;    // Current state
  fifo_s s_nxt;  // Next state
  logic  push;   // Word taken in
  logic  pop;    // Word handed out

  // Handshakes straight from the count
  assign in_ready  = (s.cnt != FULL);
  assign out_valid = (s.cnt != '0);
  assign out_data  = s.mem[s.rd];
  assign count     = s.cnt;
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  // Pointer and count update
  always_comb
  begin
    s_nxt = s;
    if (flush)
    begin
      // Drop everything held
      s_nxt.rd  = '0;
      s_nxt.wr  = '0;
      s_nxt.cnt = '0;
    end
    else
    begin
      if (push)
      begin
        s_nxt.mem[s.wr] = in_data;
        s_nxt.wr        = (s.wr == LAST) ? '0 : s.wr + 1'b1;
      end
      if (pop)
        s_nxt.rd = (s.rd == LAST) ? '0 : s.rd + 1'b1;
      // Count moves only on unbalanced traffic
      if (push && !pop)
        s_nxt.cnt = s.cnt + 1'b1;
      else if (pop && !push)
        s_nxt.cnt = s.cnt - 1'b1;
    end
  end

  // State register
  always_ff @(posedge clk)
  begin
    if (rst)
      s <= '0;
    else
      s <= s_nxt;
  end
endmodule // cell_fifo

// One link port: transmit and receive slot engines
module tdm_link_timeslot_port #(
  parameter int LINK_INDEX = 0,
  parameter int FIFO_DEPTH = `CELL_BYTES * `FIFO_CELLS
) (
  input  wire logic        CLK_SYS,
  input  wire logic        RESET,
  input  wire logic [15:0] ADDR,
  input  wire logic [15:0] WDATA,
  input  wire logic        WR,
  input  wire logic        RD,
  output logic      [15:0] RDATA,
  input  wire logic [15:0] RECOMB_ACTIVE,
  input  wire logic        TX_SERIAL_CLOCK,
  input  wire logic        TX_FRAME_PULSE,
  input  wire logic        LEAD_TX_SERIAL_CLOCK,
  input  wire logic        LEAD_TX_FRAME_PULSE,
  output logic             SERIAL_DATA_OUT,
  output logic             SERIAL_DATA_OE,
  output logic             LEAD_DATA_OUT,
  output logic             LEAD_DATA_OE,
  input  wire logic        RX_SERIAL_CLOCK,
  input  wire logic        RX_FRAME_PULSE,
  input  wire logic        SERIAL_DATA_IN,
  input  wire logic        LEAD_RX_SERIAL_CLOCK,
  input  wire logic        LEAD_RX_FRAME_PULSE,
  input  wire logic        LEAD_DATA_IN,
  input  wire logic [7:0]  TX_DATA,
  input  wire logic        TX_VALID,
  output logic             TX_READY,
  output logic      [7:0]  CELL_DATA,
  output logic             CELL_VALID,
  input  wire logic        CELL_READY
);
  localparam logic [1:0] IDX = 2'(LINK_INDEX);
  localparam int CW = $clog2(FIFO_DEPTH + 1);

  // Whole port state
  typedef struct packed {
    logic [15:0]         tx_ctrl;   // Transmit control
    logic [15:0]         rx_ctrl;   // Receive control
    logic [31:0]         tx_mask;   // Transmit slot mask
    logic [31:0]         rx_mask;   // Receive slot mask
    tdm_link_pkg::pins_s sync1;     // First sampling stage
    tdm_link_pkg::pins_s sync2;     // Second sampling stage
    logic                tx_clk_q;  // Previous transmit clock
    logic                tx_ph;     // Transmit half-bit phase
    logic [8:0]          tx_cnt;    // Transmit bit in frame
    logic [7:0]          tx_sh;     // Transmit shifter
    logic                tx_out;    // Bit on the wire
    logic                tx_oe;     // Own pin drive
    logic                tx_goe;    // Leader wire drive
    logic                rx_clk_q;  // Previous receive clock
    logic                rx_ph;     // Receive half-bit phase
    logic [8:0]          rx_cnt;    // Receive bit in frame
    logic [7:0]          rx_sh;     // Receive shifter
    logic [5:0]          cbyte;     // Byte within cell
    logic [31:0]         hdr;       // Held cell header
    logic                drop;      // Current cell is idle
    logic [2:0]          replay;    // Header bytes to push
    logic                pend_v;    // Payload byte waiting
    logic [7:0]          pend_b;    // Waiting payload byte
    logic                ovf;       // Sticky overflow
    logic                port_en_q; // Previous port enable
    logic [15:0]         rdata;     // Read answer
  } port_s;

  port_s               s;        // Current state
  port_s               s_nxt;    // Next state
  tdm_link_pkg::pins_s pins_raw; // Pins as they arrive
  tdm_link_pkg::step_s tst;      // Transmit timing step
  tdm_link_pkg::step_s rst_s;    // Receive timing step
  tdm_link_pkg::pos_s  tpos;     // Transmit frame position
  tdm_link_pkg::pos_s  rpos;     // Receive frame position
  tdm_link_pkg::mux_e  tx_mux;   // Transmit grouping
  tdm_link_pkg::mux_e  rx_mux;   // Receive grouping
  logic                tx_fol;   // Transmit follows leader
  logic                rx_fol;   // Receive follows leader
  logic                tact;     // Transmit slot active
  logic                ract;     // Receive slot active
  logic                tx_rdy_c; // Transmit byte taken
  logic [7:0]          tb;       // Byte loaded for sending
  logic [7:0]          rb;       // Byte just received
  logic                din;      // Selected receive data
  logic                f_in_rdy; // FIFO has room
  logic                f_valid;  // FIFO has data
  logic [CW-1:0]       f_cnt;    // FIFO fill
  logic                wr_v;     // Byte offered to FIFO
  logic [7:0]          wr_b;     // Byte offered to FIFO
  logic                flush;    // FIFO flush pulse
  logic                port_en;  // Cell port enabled
  logic                ovf_set;  // Byte lost this cycle

  // Timing step on a sampled serial clock edge
  function automatic tdm_link_pkg::step_s step(
    input logic       now,
    input logic       prev,
    input logic       fall,
    input logic       fp_act,
    input logic       bus,
    input logic       ph,
    input logic [8:0] cnt
  );
    tdm_link_pkg::step_s r;
    r = '{ev: 1'b0, ph: ph, cnt: cnt};
    if (fall ? (prev & ~now) : (~prev & now))
    begin
      if (bus && ph)
        r.ph = 1'b0;  // Second clock of a bus bit
      else if (fp_act)
      begin
        // Pulse marks bit zero of the frame
        r = '{ev: 1'b1, ph: bus, cnt: 9'h000};
      end
      else
      begin
        r.ev  = 1'b1;
        r.ph  = bus;
        r.cnt = (cnt == `CNT_MAX) ? cnt : cnt + 9'h001;
      end
    end
    return r;
  endfunction

  // Slot and bit of a frame count
  function automatic tdm_link_pkg::pos_s slot_pos(input logic [8:0] cnt, input logic t1);
    logic [8:0] c;
    c = t1 ? cnt - 9'h001 : cnt;
    // T1 framing bit carries nothing
    slot_pos.valid = t1 ? (cnt != 9'h000 && c < `T1_PAYLOAD_BITS) : (cnt < `E1_FRAME_BITS);
    slot_pos.slot  = c[7:3];
    slot_pos.bit_i = c[2:0];
  endfunction

  // Whether this link takes its timing from the group leader
  function automatic logic follower(input tdm_link_pkg::mux_e m);
    return (m == tdm_link_pkg::MUX_PAIR && IDX[0]) ||
           (m == tdm_link_pkg::MUX_QUAD && IDX != 2'h0);
  endfunction

  // Pins gathered for sampling
  assign pins_raw = '{tx_clk: TX_SERIAL_CLOCK, tx_fp: TX_FRAME_PULSE,
                      ltx_clk: LEAD_TX_SERIAL_CLOCK, ltx_fp: LEAD_TX_FRAME_PULSE,
                      rx_clk: RX_SERIAL_CLOCK, rx_fp: RX_FRAME_PULSE, rx_d: SERIAL_DATA_IN,
                      lrx_clk: LEAD_RX_SERIAL_CLOCK, lrx_fp: LEAD_RX_FRAME_PULSE, lrx_d: LEAD_DATA_IN};

  // Control field decode
  assign tx_mux  = tdm_link_pkg::mux_e'(s.tx_ctrl[`FLD_MUX_HI:`FLD_MUX_LO]);
  assign rx_mux  = tdm_link_pkg::mux_e'(s.rx_ctrl[`FLD_MUX_HI:`FLD_MUX_LO]);
  assign tx_fol  = follower(tx_mux);
  assign rx_fol  = follower(rx_mux);
  assign port_en = s.rx_ctrl[`FLD_PORT_EN];
  assign flush   = port_en & ~s.port_en_q;

  // Outputs from flops; TX_READY and CELL_VALID decoded from state
  assign RDATA           = s.rdata;
  assign SERIAL_DATA_OUT = s.tx_out;
  assign SERIAL_DATA_OE  = s.tx_oe;
  assign LEAD_DATA_OUT   = s.tx_out;
  assign LEAD_DATA_OE    = s.tx_goe;
  assign TX_READY        = tx_rdy_c;
  assign CELL_VALID      = f_valid & port_en;

  // FIFO write side: header replay first, then payload
  assign wr_v = (s.replay != 3'h0) | s.pend_v;
  assign wr_b = (s.replay != 3'h0) ? s.hdr[31:24] : s.pend_b;

  // Receive cell FIFO, four cells deep
  cell_fifo #(
    .WIDTH (8),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk       (CLK_SYS),
    .rst       (RESET),
    .flush     (flush),
    .in_data   (wr_b),
    .in_valid  (wr_v),
    .in_ready  (f_in_rdy),
    .out_data  (CELL_DATA),
    .out_valid (f_valid),
    .out_ready (CELL_READY & port_en),
    .count     (f_cnt)
  );

  // Next state of the whole port
  always_comb
  begin
    s_nxt    = s;
    tx_rdy_c = 1'b0;
    tact     = 1'b0;
    ract     = 1'b0;
    tb       = 8'h00;
    rb       = 8'h00;
    ovf_set  = 1'b0;
    s_nxt.sync1     = pins_raw;
    s_nxt.sync2     = s.sync1;
    s_nxt.port_en_q = port_en;
    s_nxt.rdata     = 16'h0000;

    // Transmit timing, own pins or leader's
    tst = step(tx_fol ? s.sync2.ltx_clk : s.sync2.tx_clk, s.tx_clk_q, s.tx_ctrl[`FLD_EDGE],
               (tx_fol ? s.sync2.ltx_fp : s.sync2.tx_fp) == s.tx_ctrl[`FLD_FP_POL],
               s.tx_ctrl[`FLD_BUS], s.tx_ph, s.tx_cnt);
    s_nxt.tx_clk_q = tx_fol ? s.sync2.ltx_clk : s.sync2.tx_clk;
    s_nxt.tx_ph    = tst.ph;
    s_nxt.tx_cnt   = tst.cnt;
    tpos = slot_pos(tst.cnt, s.tx_ctrl[`FLD_RATE_HI:`FLD_RATE_LO] == `RATE_T1);

    // Transmit bit engine, independent of receive
    if (!s.tx_ctrl[`FLD_EN])
    begin
      s_nxt.tx_oe  = 1'b0;
      s_nxt.tx_goe = 1'b0;
    end
    else if (tst.ev)
    begin
      tact = tpos.valid & s.tx_mask[tpos.slot];
      if (tact && tpos.bit_i == 3'h0)
      begin
        // Slot start: take a byte, zero when none offered
        tx_rdy_c     = 1'b1;
        tb           = TX_VALID ? TX_DATA : 8'h00;
        s_nxt.tx_out = tb[7];
        s_nxt.tx_sh  = {tb[6:0], 1'b0};
      end
      else
      begin
        s_nxt.tx_out = s.tx_sh[7];
        s_nxt.tx_sh  = {s.tx_sh[6:0], 1'b0};
      end
      // Idle slot floats; follower drives leader wire only
      s_nxt.tx_oe  = tact & ~tx_fol;
      s_nxt.tx_goe = tact & tx_fol;
    end

    // Receive timing, own pins or leader's
    rst_s = step(rx_fol ? s.sync2.lrx_clk : s.sync2.rx_clk, s.rx_clk_q, s.rx_ctrl[`FLD_EDGE],
                 (rx_fol ? s.sync2.lrx_fp : s.sync2.rx_fp) == s.rx_ctrl[`FLD_FP_POL],
                 s.rx_ctrl[`FLD_BUS], s.rx_ph, s.rx_cnt);
    s_nxt.rx_clk_q = rx_fol ? s.sync2.lrx_clk : s.sync2.rx_clk;
    s_nxt.rx_ph    = rst_s.ph;
    s_nxt.rx_cnt   = rst_s.cnt;
    rpos = slot_pos(rst_s.cnt, s.rx_ctrl[`FLD_RATE_HI:`FLD_RATE_LO] == `RATE_T1);
    din  = rx_fol ? s.sync2.lrx_d : s.sync2.rx_d;

    // FIFO write accepted
    if (wr_v && f_in_rdy)
    begin
      if (s.replay != 3'h0)
      begin
        s_nxt.hdr    = {s.hdr[23:0], 8'h00};
        s_nxt.replay = s.replay - 3'h1;
      end
      else
        s_nxt.pend_v = 1'b0;
    end

    // Receive bit engine
    if (!s.rx_ctrl[`FLD_EN] || !port_en)
      s_nxt.cbyte = 6'h00;
    else if (rst_s.ev)
    begin
      ract = rpos.valid & s.rx_mask[rpos.slot];
      if (ract)
      begin
        s_nxt.rx_sh = {s.rx_sh[6:0], din};
        rb          = {s.rx_sh[6:0], din};
        if (rpos.bit_i == 3'h7)
        begin
          // Byte complete; cell boundary kept by byte count
          s_nxt.cbyte = (s.cbyte == `CELL_LAST) ? 6'h00 : s.cbyte + 6'h01;
          if (s.cbyte <= `HDR_LAST)
          begin
            s_nxt.hdr = {s.hdr[23:0], rb};
            if (s.cbyte == `HDR_LAST)
            begin
              // Idle header: whole cell dropped
              s_nxt.drop   = ({s.hdr[23:0], rb} == `IDLE_HDR);
              s_nxt.replay = s_nxt.drop ? 3'h0 : `HDR_BYTES;
            end
          end
          else if (!s.drop)
          begin
            // Writer stalls on a full FIFO; a second byte is lost
            if (s.pend_v && !(wr_v && f_in_rdy && s.replay == 3'h0))
              ovf_set = 1'b1;
            else
            begin
              s_nxt.pend_v = 1'b1;
              s_nxt.pend_b = rb;
            end
          end
        end
      end
    end

    // Flush drops waiting bytes
    if (flush)
    begin
      s_nxt.replay = 3'h0;
      s_nxt.pend_v = 1'b0;
    end

    // Register writes
    if (WR)
    begin
      unique case (ADDR)
        `ADDR_TX_CTRL:    s_nxt.tx_ctrl       = WDATA;
        `ADDR_RX_CTRL:    s_nxt.rx_ctrl       = WDATA;
        `ADDR_TX_MASK_LO: s_nxt.tx_mask[15:0]  = WDATA;
        `ADDR_TX_MASK_HI: s_nxt.tx_mask[31:16] = WDATA;
        `ADDR_RX_MASK_LO: s_nxt.rx_mask[15:0]  = WDATA;
        `ADDR_RX_MASK_HI: s_nxt.rx_mask[31:16] = WDATA;
        default:          ;
      endcase
    end
    // Overflow: write one clears, a new loss wins
    s_nxt.ovf = (s.ovf & ~(WR && ADDR == `ADDR_RX_STAT && WDATA[`STAT_OVF])) | ovf_set;

    // Register reads, answered next cycle
    if (RD)
    begin
      unique case (ADDR)
        `ADDR_TX_CTRL:     s_nxt.rdata = s.tx_ctrl;
        `ADDR_RX_CTRL:     s_nxt.rdata = s.rx_ctrl;
        `ADDR_TX_MASK_LO:  s_nxt.rdata = s.tx_mask[15:0];
        `ADDR_TX_MASK_HI:  s_nxt.rdata = s.tx_mask[31:16];
        `ADDR_RX_MASK_LO:  s_nxt.rdata = s.rx_mask[15:0];
        `ADDR_RX_MASK_HI:  s_nxt.rdata = s.rx_mask[31:16];
        `ADDR_RECOMB_STAT: s_nxt.rdata = RECOMB_ACTIVE;
        `ADDR_RX_STAT:
        begin
          s_nxt.rdata[`STAT_OVF]   = s.ovf;
          s_nxt.rdata[`STAT_EMPTY] = ~f_valid;
          s_nxt.rdata[`STAT_CNT_HI:`STAT_CNT_LO] = 8'(f_cnt);
        end
        default:           s_nxt.rdata = 16'h0000;
      endcase
    end
  end

  // State register, synchronous reset
  always_ff @(posedge CLK_SYS)
  begin
    if (RESET)
      s <= '0;
    else
      s <= s_nxt;
  end
endmodule // tdm_link_timeslot_port

// ==== tdm_link_timeslot_port_asserts.sv ====
// Checker of the serial link port
`include "tdm_link_params.svh"
module tdm_link_timeslot_port_asserts #(
  parameter int LINK_INDEX = 0
) (
  input wire logic        CLK_SYS,
  input wire logic        RESET,
  input wire logic [15:0] ADDR,
  input wire logic [15:0] WDATA,
  input wire logic        WR,
  input wire logic        RD,
  input wire logic [15:0] RDATA,
  input wire logic [15:0] RECOMB_ACTIVE,
  input wire logic        SERIAL_DATA_OE,
  input wire logic        LEAD_DATA_OE,
  input wire logic        TX_READY,
  input wire logic        CELL_VALID
);
  // Shadow control words
  typedef struct packed {
    logic [15:0] tx;
    logic [15:0] rx;
  } shadow_s;
  shadow_s st_r;
  shadow_s st_nxt;
  logic    tx_en;     // Transmit enabled
  logic    tx_follow; // Timed from the group leader
  logic    unmapped;  // Address outside the map
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (RESET);
  // Follow control writes
  always_comb
  begin
    st_nxt = st_r;
    if (WR && ADDR == `ADDR_TX_CTRL)
      st_nxt.tx = WDATA;
    if (WR && ADDR == `ADDR_RX_CTRL)
      st_nxt.rx = WDATA;
  end
  // Register the shadow
  always_ff @(posedge CLK_SYS)
    st_r <= RESET ? '0 : st_nxt;
  assign tx_en = st_r.tx[7];
  assign tx_follow = (st_r.tx[4:3] == 2'h1 && LINK_INDEX % 2 == 1) || (st_r.tx[4:3] == 2'h2 && LINK_INDEX % 4 != 0);
  assign unmapped = !(ADDR inside {`ADDR_RECOMB_STAT, `ADDR_TX_CTRL, `ADDR_TX_MASK_LO, `ADDR_TX_MASK_HI,
    `ADDR_RX_CTRL, `ADDR_RX_MASK_LO, `ADDR_RX_MASK_HI, `ADDR_RX_STAT});
  a_rdata_idle: assert property (!$past(RD) |-> RDATA == 16'h0000)
    else $error("stray read data");
  a_unmapped_zero: assert property (RD && unmapped |=> RDATA == 16'h0000)
    else $error("unmapped read");
  a_ctrl_readback: assert property (RD && ADDR == `ADDR_TX_CTRL |=> RDATA == st_r.tx)
    else $error("control readback");
  a_recomb_read: assert property (RD && ADDR == `ADDR_RECOMB_STAT |=> RDATA == $past(RECOMB_ACTIVE))
    else $error("status readback");
  a_off_quiet: assert property (!tx_en [*3] |-> !SERIAL_DATA_OE && !LEAD_DATA_OE)
    else $error("drive while off");
  a_follow_quiet: assert property ((tx_en && tx_follow) [*3] |-> !SERIAL_DATA_OE)
    else $error("follower drives");
  a_lead_quiet: assert property ((tx_en && !tx_follow) [*3] |-> !LEAD_DATA_OE)
    else $error("stray leader drive");
  a_ready_pulse: assert property (TX_READY |-> tx_en ##1 !TX_READY)
    else $error("ready too long");
  a_port_gate: assert property (!st_r.rx[8] [*2] |-> !CELL_VALID)
    else $error("output while off");
  a_flush_empty: assert property ($rose(st_r.rx[8]) |-> ##1 !CELL_VALID)
    else $error("no flush");
  c_tx_byte: cover property (TX_READY);
  c_cell_out: cover property (CELL_VALID);
  c_port_on: cover property ($rose(st_r.rx[8]));
endmodule // tdm_link_timeslot_port_asserts

bind tdm_link_timeslot_port tdm_link_timeslot_port_asserts #(.LINK_INDEX(LINK_INDEX)) u_chk (
  .CLK_SYS, .RESET, .ADDR, .WDATA, .WR, .RD, .RDATA, .RECOMB_ACTIVE, .SERIAL_DATA_OE, .LEAD_DATA_OE,
  .TX_READY, .CELL_VALID);

// ==== tdm_far_end_model.sv ====
// Far-end framer model
module tdm_far_end_model (
  input  wire logic        run,
  input  wire logic        t1,
  input  wire logic [31:0] rx_mask,
  input  wire logic        tx_d,
  input  wire logic        tx_oe,
  output logic             lclk,
  output logic             tx_fp,
  output logic             rx_fp_n,
  output logic             rx_d
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0]  rxq [$];       // Bytes queued toward the port
  logic [7:0]  sh [32];       // Bytes seen per slot
  logic [7:0]  cap_byte [32]; // Bytes of the last frame
  logic [31:0] run_oe;        // Slots driven this frame
  logic [31:0] cap_oe;        // Slots driven in the last frame
  logic        fbit_oe;       // Drive seen on the framing bit
  logic [7:0]  cur;           // Byte being sent
  int          frames;        // Completed frames
  int          s;             // Slot of this bit, -1 on framing bit
  int          b;             // Bit within the slot
  // Whole frames; clock idle between them
  initial
  begin
    lclk = 1'b0;
    tx_fp = 1'b0;
    rx_fp_n = 1'b1;
    rx_d = 1'b0;
    fbit_oe = 1'b0;
    cur = 8'h00;
    frames = 0;
    forever
    begin
      wait (run === 1'b1);
      run_oe = '0;
      tx_fp = 1'b1;
      #400;
      for (int k = 0; k < (t1 ? 193 : 256); k++)
      begin
        s = t1 ? (k + 7) / 8 - 1 : k / 8;
        b = t1 ? (k + 7) % 8 : k % 8;
        lclk = 1'b1;
        // Junk in idle slots, zero fillers after the queue
        if (s >= 0 && b == 0)
          cur = !rx_mask[s] ? 8'ha5 : (rxq.size() > 0 ? rxq.pop_front() : 8'h00);
        rx_d = s < 0 ? !rx_d : cur[7 - b];
        rx_fp_n = (k != 0);
        #400;
        lclk = 1'b0;
        tx_fp = (k == (t1 ? 192 : 255));
        #350;
        if (s < 0)
          fbit_oe = tx_oe;
        else if (tx_oe === 1'b1)
        begin
          run_oe[s] = 1'b1;
          sh[s] = {sh[s][6:0], tx_d};
        end
        #50;
      end
      cap_byte = sh;
      cap_oe = run_oe;
      frames++;
    end
  end
endmodule // tdm_far_end_model

// ==== tdm_link_timeslot_port_tb.sv ====
// Testbench of the serial link port
`include "tdm_link_params.svh"
module tdm_link_timeslot_port_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        CLK_SYS = 1'b0;
  logic        RESET, WR, RD, TX_VALID, CELL_READY, run, t1;
  logic [15:0] ADDR, WDATA, RECOMB_ACTIVE, RDATA, d;
  logic [7:0]  TX_DATA, CELL_DATA;
  logic [31:0] rx_mask;
  logic        SERIAL_DATA_OUT, SERIAL_DATA_OE, LEAD_DATA_OUT, LEAD_DATA_OE, TX_READY, CELL_VALID;
  logic        lclk, tx_fp, rx_fp_n, rx_d;
  int          n_mismatch, n_tests;
  logic [7:0]  expq [$]; // Cell bytes still expected out
  logic [15:0] regs [6] = '{`ADDR_TX_CTRL, `ADDR_TX_MASK_LO, `ADDR_TX_MASK_HI, `ADDR_RX_CTRL,
                            `ADDR_RX_MASK_LO, `ADDR_RX_MASK_HI};
  wire         tx_oe = SERIAL_DATA_OE | LEAD_DATA_OE;
  wire         tx_d = SERIAL_DATA_OE ? SERIAL_DATA_OUT : LEAD_DATA_OUT;
  // Leader pins tied to the far end
  tdm_link_timeslot_port #(.LINK_INDEX(1)) dut (
    .CLK_SYS, .RESET, .ADDR, .WDATA, .WR, .RD, .RDATA, .RECOMB_ACTIVE, .TX_SERIAL_CLOCK(lclk),
    .TX_FRAME_PULSE(tx_fp), .LEAD_TX_SERIAL_CLOCK(lclk), .LEAD_TX_FRAME_PULSE(tx_fp), .SERIAL_DATA_OUT,
    .SERIAL_DATA_OE, .LEAD_DATA_OUT, .LEAD_DATA_OE, .RX_SERIAL_CLOCK(lclk), .RX_FRAME_PULSE(rx_fp_n),
    .SERIAL_DATA_IN(rx_d), .LEAD_RX_SERIAL_CLOCK(lclk), .LEAD_RX_FRAME_PULSE(rx_fp_n), .LEAD_DATA_IN(rx_d),
    .TX_DATA, .TX_VALID, .TX_READY, .CELL_DATA, .CELL_VALID, .CELL_READY);
  tdm_far_end_model fe (.run, .t1, .rx_mask, .tx_d, .tx_oe, .lclk, .tx_fp, .rx_fp_n, .rx_d);
  always #50 CLK_SYS = ~CLK_SYS;
  // Compare one value
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // Report and stop
  task automatic end_of_test;
    $display("%0d mismatches in %0d comparisons", n_mismatch, n_tests);
    if (n_mismatch == 0 && n_tests > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // One-cycle register write
  task automatic wr(input logic [15:0] a, input logic [15:0] v);
    @(posedge CLK_SYS);
    ADDR <= a;
    WDATA <= v;
    WR <= 1'b1;
    @(posedge CLK_SYS);
    WR <= 1'b0;
  endtask
  // Register read
  task automatic rd(input logic [15:0] a, output logic [15:0] v);
    @(posedge CLK_SYS);
    ADDR <= a;
    RD <= 1'b1;
    @(posedge CLK_SYS);
    RD <= 1'b0;
    @(negedge CLK_SYS);
    v = RDATA;
  endtask
  task automatic rdchk(input logic [15:0] a, input logic [15:0] exp);
    logic [15:0] v;
    rd(a, v);
    chk(v, exp);
  endtask
  // Run whole frames
  task automatic run_frames(input int cnt);
    int tgt;
    tgt = fe.frames + cnt;
    run <= 1'b1;
    for (int i = 0; i < 30000 && fe.frames < tgt; i++)
    begin
      @(posedge CLK_SYS);
      if (fe.frames >= tgt - 1)
        run <= 1'b0;
    end
    if (fe.frames != tgt)
    begin
      n_mismatch++;
      $display("MISMATCH %0t frames stalled", $time);
      end_of_test();
    end
  endtask
  // Queue one cell at the far end
  task automatic push_cell(input logic [31:0] hdr, input logic [7:0] base, input logic keep);
    logic [7:0] v;
    for (int i = 0; i < `CELL_BYTES; i++)
    begin
      v = i < 4 ? hdr[31 - 8 * i -: 8] : base + 8'(i);
      fe.rxq.push_back(v);
      if (keep)
        expq.push_back(v);
    end
  endtask
  // Next transmit byte
  always @(posedge CLK_SYS)
    if (TX_READY === 1'b1 && TX_VALID === 1'b1)
      TX_DATA <= TX_DATA + 8'h01;
  // Cell bytes leave in order
  always @(posedge CLK_SYS)
    if (CELL_VALID === 1'b1 && CELL_READY === 1'b1 && expq.size() > 0)
      chk({8'h00, CELL_DATA}, {8'h00, expq.pop_front()});
  // Main sequence
  initial
  begin
    RESET = 1'b1;
    {ADDR, WDATA, WR, RD, TX_VALID, CELL_READY, run, t1, rx_mask} = '0;
    RECOMB_ACTIVE = 16'h0024;
    TX_DATA = 8'h10;
    n_mismatch = 0;
    n_tests = 0;
    repeat (6) @(posedge CLK_SYS);
    RESET <= 1'b0;
    foreach (regs[i]) rdchk(regs[i], 16'h0000);
    rdchk(`ADDR_RECOMB_STAT, 16'h0024);
    wr(16'h0612, 16'hffff);
    rdchk(16'h0612, 16'h0000);
    // 2.048 MHz generic: slots 0, 2, 30 out; slots 4..31 in
    wr(`ADDR_TX_MASK_LO, 16'h0005);
    wr(`ADDR_TX_MASK_HI, 16'h4000);
    wr(`ADDR_TX_CTRL, 16'h00a1);
    rdchk(`ADDR_TX_CTRL, 16'h00a1);
    rdchk(`ADDR_TX_MASK_HI, 16'h4000);
    wr(`ADDR_RX_MASK_LO, 16'hfff0);
    wr(`ADDR_RX_MASK_HI, 16'hffff);
    wr(`ADDR_RX_CTRL, 16'h01a2);
    rx_mask <= 32'hfffffff0;
    TX_VALID <= 1'b1;
    CELL_READY <= 1'b1;
    push_cell(32'h00000001, 8'h40, 1'b0);
    push_cell(32'h11223344, 8'h00, 1'b1);
    push_cell(32'haabbccdd, 8'h80, 1'b1);
    run_frames(7);
    chk(16'(expq.size()), 16'h0000);
    chk(fe.cap_oe[15:0], 16'h0005);
    chk(fe.cap_oe[31:16], 16'h4000);
    chk({fe.cap_byte[0], fe.cap_byte[2]}, 16'h2223);
    chk({8'h00, fe.cap_byte[30]}, 16'h0024);
    // Overfill the four-cell FIFO with five cells, then flush
    CELL_READY <= 1'b0;
    wr(`ADDR_RX_CTRL, 16'h00a2);
    wr(`ADDR_RX_CTRL, 16'h01a2);
    repeat (5) push_cell(32'h0a0b0c0d, 8'h20, 1'b0);
    run_frames(10);
    rdchk(`ADDR_RX_STAT, 16'hd401);
    wr(`ADDR_RX_CTRL, 16'h00a2);
    wr(`ADDR_RX_CTRL, 16'h01a2);
    rd(`ADDR_RX_STAT, d);
    chk(d & 16'hff02, 16'h0002);
    wr(`ADDR_RX_STAT, 16'h0001);
    rdchk(`ADDR_RX_STAT, 16'h0002);
    // 1.544 MHz pair: odd link drives the leader wire
    wr(`ADDR_RX_CTRL, 16'h0000);
    wr(`ADDR_TX_MASK_LO, 16'h0001);
    wr(`ADDR_TX_MASK_HI, 16'h0140);
    wr(`ADDR_TX_CTRL, 16'h0089);
    t1 <= 1'b1;
    TX_DATA <= 8'h50;
    run_frames(2);
    chk(fe.cap_oe[15:0], 16'h0001);
    chk(fe.cap_oe[31:16], 16'h0040);
    chk({fe.cap_byte[0], fe.cap_byte[22]}, 16'h5253);
    chk({15'h0000, fe.fbit_oe}, 16'h0000);
    end_of_test();
  end
endmodule // tdm_link_timeslot_port_tb
